/* hdl/bse_core.sv */
// Purpose: Executes bit set/clear and conditional skip operations.
// Assumes: One operation per valid cycle, single sys_clk, sync reset.
// Notes:   Depths must be powers of two; operand addresses wrap.
// Functional notes
// - IO bit clear drives only bit n low, others unchanged.
// - IO bit set drives only bit n high, others unchanged.
// - Memory bit clear writes 0 into bit n, others kept.
// - Memory bit set writes 1 into bit n, others kept.
// - Compare working register with immediate, skip next when equal.
// - Compare working register with memory byte, skip next when equal.
// - Compares set all four flags as working register minus operand.
// - Test IO bit n, skip next when it is 0.
// - Test IO bit n, skip next when it is 1.
// - Test memory bit n, skip next when it is 0.
// - Test memory bit n, skip next when it is 1.
// - Increment working register, store, skip next when result zero.
// - Decrement working register, store, skip next when result zero.
// - Increment memory byte, write back, skip next when result zero.
// - Decrement memory byte, write back, skip next when result zero.
// - Increment and decrement skips update all four arithmetic flags.
// - Bit set, clear and test leave the four flags unchanged.
`timescale 1ns/1ps
`default_nettype none

module bse_core #(
    parameter int IO_DEPTH = 16,
    parameter int MEM_DEPTH = 64
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire bse_pkg::bse_op_t instr_op,
    input wire logic [7:0] instr_addr,
    input wire logic [2:0] instr_bit,
    input wire logic [7:0] instr_imm,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [7:0] bus_rdata,
    output logic [7:0] working_register,
    output logic zero_flag,
    output logic carry_flag,
    output logic half_carry_flag,
    output logic overflow_flag,
    output logic skip_pending,
    output logic instr_discarded
);

    localparam int IO_IW = $clog2(IO_DEPTH);
    localparam int MEM_IW = $clog2(MEM_DEPTH);

    // Storage
    logic [7:0] io_regs [IO_DEPTH];
    logic [7:0] mem [MEM_DEPTH];
    logic [bse_pkg::FLAG_W-1:0] flags;

    // Operand indices and bytes
    logic [IO_IW-1:0] io_idx;
    logic [MEM_IW-1:0] mem_idx;
    logic [7:0] io_byte;
    logic [7:0] mem_byte;
    logic [7:0] bit_mask;

    // Decoded actions of the current operation
    logic live;
    logic discard;
    logic is_arith;
    logic is_sub;
    logic [7:0] opa;
    logic [7:0] opb;
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] result;
    logic next_carry;
    logic next_half;
    logic next_ov;
    logic skip_cond;
    logic acc_we;
    logic io_we;
    logic mem_we;
    logic [7:0] io_wval;
    logic [7:0] mem_wval;

    // Register port decode
    logic [7:0] bus_io_off;
    logic [7:0] bus_mem_off;
    logic bus_in_io;
    logic bus_in_mem;
    logic [IO_IW-1:0] bus_io_idx;
    logic [MEM_IW-1:0] bus_mem_idx;
    logic [7:0] flag_byte;
    logic [7:0] status_byte;
    logic [7:0] next_rdata;

    assign io_idx = instr_addr[IO_IW-1:0];
    assign mem_idx = instr_addr[MEM_IW-1:0];
    assign io_byte = io_regs[io_idx];
    assign mem_byte = mem[mem_idx];
    assign bit_mask = bse_pkg::BIT0_MASK << instr_bit;

    // A pending skip swallows the next issued operation; idle cycles
    // leave it armed, so the skip always lands on a real issue slot
    assign live = instr_valid & ~skip_pending;
    assign discard = instr_valid & skip_pending;

    // Operand selection, write-back targets and skip condition
    always_comb begin
        is_arith = 1'b0;
        is_sub = 1'b0;
        opa = working_register;
        opb = bse_pkg::ONE;
        acc_we = 1'b0;
        io_we = 1'b0;
        mem_we = 1'b0;
        io_wval = io_byte;
        mem_wval = mem_byte;
        skip_cond = 1'b0;
        case (instr_op)
            bse_pkg::OP_BIT_CLEAR_IO: begin
                io_we = 1'b1;
                io_wval = io_byte & ~bit_mask;
            end
            bse_pkg::OP_BIT_SET_IO: begin
                io_we = 1'b1;
                io_wval = io_byte | bit_mask;
            end
            bse_pkg::OP_BIT_CLEAR_MEM: begin
                mem_we = 1'b1;
                mem_wval = mem_byte & ~bit_mask;
            end
            bse_pkg::OP_BIT_SET_MEM: begin
                mem_we = 1'b1;
                mem_wval = mem_byte | bit_mask;
            end
            bse_pkg::OP_CMP_IMM: begin
                is_arith = 1'b1;
                is_sub = 1'b1;
                opb = instr_imm;
                skip_cond = (working_register == instr_imm);
            end
            bse_pkg::OP_CMP_MEM: begin
                is_arith = 1'b1;
                is_sub = 1'b1;
                opb = mem_byte;
                skip_cond = (working_register == mem_byte);
            end
            bse_pkg::OP_TEST_LOW_IO: begin
                skip_cond = ~io_byte[instr_bit];
            end
            bse_pkg::OP_TEST_HIGH_IO: begin
                skip_cond = io_byte[instr_bit];
            end
            bse_pkg::OP_TEST_LOW_MEM: begin
                skip_cond = ~mem_byte[instr_bit];
            end
            bse_pkg::OP_TEST_HIGH_MEM: begin
                skip_cond = mem_byte[instr_bit];
            end
            bse_pkg::OP_INC_WREG: begin
                is_arith = 1'b1;
                acc_we = 1'b1;
                skip_cond = (result == bse_pkg::ZERO_BYTE);
            end
            bse_pkg::OP_DEC_WREG: begin
                is_arith = 1'b1;
                is_sub = 1'b1;
                acc_we = 1'b1;
                skip_cond = (result == bse_pkg::ZERO_BYTE);
            end
            bse_pkg::OP_INC_MEM: begin
                is_arith = 1'b1;
                opa = mem_byte;
                mem_we = 1'b1;
                mem_wval = result;
                skip_cond = (result == bse_pkg::ZERO_BYTE);
            end
            bse_pkg::OP_DEC_MEM: begin
                is_arith = 1'b1;
                is_sub = 1'b1;
                opa = mem_byte;
                mem_we = 1'b1;
                mem_wval = result;
                skip_cond = (result == bse_pkg::ZERO_BYTE);
            end
            default: begin
                skip_cond = 1'b0;
            end
        endcase
    end

    // Adder/subtractor with borrow, half borrow and signed overflow
    always_comb begin
        if (is_sub) begin
            full = {1'b0, opa} - {1'b0, opb};
            low = {1'b0, opa[bse_pkg::NIB_W-1:0]}
                - {1'b0, opb[bse_pkg::NIB_W-1:0]};
        end else begin
            full = {1'b0, opa} + {1'b0, opb};
            low = {1'b0, opa[bse_pkg::NIB_W-1:0]}
                + {1'b0, opb[bse_pkg::NIB_W-1:0]};
        end
        result = full[bse_pkg::DATA_W-1:0];
        next_carry = full[bse_pkg::DATA_W];
        next_half = low[bse_pkg::NIB_W];
        if (is_sub) begin
            next_ov = (opa[bse_pkg::SIGN_BIT] != opb[bse_pkg::SIGN_BIT])
                & (result[bse_pkg::SIGN_BIT] != opa[bse_pkg::SIGN_BIT]);
        end else begin
            next_ov = (opa[bse_pkg::SIGN_BIT] == opb[bse_pkg::SIGN_BIT])
                & (result[bse_pkg::SIGN_BIT] != opa[bse_pkg::SIGN_BIT]);
        end
    end

    // Register port address decode for the IO and memory windows
    assign bus_io_off = bus_addr - bse_pkg::ADDR_IO_BASE;
    assign bus_mem_off = bus_addr - bse_pkg::ADDR_MEM_BASE;
    assign bus_in_io = (bus_addr >= bse_pkg::ADDR_IO_BASE)
        && (int'(bus_io_off) < IO_DEPTH);
    assign bus_in_mem = (bus_addr >= bse_pkg::ADDR_MEM_BASE)
        && (int'(bus_mem_off) < MEM_DEPTH);
    assign bus_io_idx = bus_io_off[IO_IW-1:0];
    assign bus_mem_idx = bus_mem_off[MEM_IW-1:0];

    // Working register; an executed operation wins over a port write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            working_register <= bse_pkg::WREG_RST;
        end else if (live && acc_we) begin
            working_register <= result;
        end else if (bus_wr && bus_addr == bse_pkg::ADDR_WREG) begin
            working_register <= bus_wdata;
        end
    end

    // Flags change only for compares, increment/decrement skips and port writes to the flag register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flags <= bse_pkg::FLAGS_RST;
        end else if (live && is_arith) begin
            flags[bse_pkg::FLAG_Z] <= (result == bse_pkg::ZERO_BYTE);
            flags[bse_pkg::FLAG_C] <= next_carry;
            flags[bse_pkg::FLAG_HALF] <= next_half;
            flags[bse_pkg::FLAG_OVF] <= next_ov;
        end else if (bus_wr && bus_addr == bse_pkg::ADDR_FLAGS) begin
            flags <= bus_wdata[bse_pkg::FLAG_W-1:0];
        end
        // Bit operations never reach the branch above
    end

    assign zero_flag = flags[bse_pkg::FLAG_Z];
    assign carry_flag = flags[bse_pkg::FLAG_C];
    assign half_carry_flag = flags[bse_pkg::FLAG_HALF];
    assign overflow_flag = flags[bse_pkg::FLAG_OVF];

    // Skip state: armed by a met condition, consumed by the next slot
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            skip_pending <= 1'b0;
            instr_discarded <= 1'b0;
        end else begin
            instr_discarded <= discard;
            if (live) begin
                skip_pending <= skip_cond;
            end else if (discard) begin
                skip_pending <= 1'b0;
            end
        end
    end

    // IO register file
    // The op write comes last so it wins over a port write to one byte
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < IO_DEPTH; i++) begin
                io_regs[i] <= bse_pkg::IO_RST;
            end
        end else begin
            if (bus_wr && bus_in_io) begin
                io_regs[bus_io_idx] <= bus_wdata;
            end
            if (live && io_we) begin
                io_regs[io_idx] <= io_wval;
            end
        end
    end

    // Data memory
    // Same ordering as the IO file: the executed op has the last word
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < MEM_DEPTH; i++) begin
                mem[i] <= bse_pkg::MEM_RST;
            end
        end else begin
            if (bus_wr && bus_in_mem) begin
                mem[bus_mem_idx] <= bus_wdata;
            end
            if (live && mem_we) begin
                mem[mem_idx] <= mem_wval;
            end
        end
    end

    // Readable views of the flag and status registers, unused bits zero
    always_comb begin
        flag_byte = bse_pkg::READ_ZERO;
        flag_byte[bse_pkg::FLAG_W-1:0] = flags;
        status_byte = bse_pkg::READ_ZERO;
        status_byte[bse_pkg::STATUS_SKIP] = skip_pending;
    end

    // Read mux; idle cycles and unmapped addresses give zero
    always_comb begin
        next_rdata = bse_pkg::READ_ZERO;
        if (bus_rd) begin
            if (bus_addr == bse_pkg::ADDR_WREG) begin
                next_rdata = working_register;
            end else if (bus_addr == bse_pkg::ADDR_FLAGS) begin
                next_rdata = flag_byte;
            end else if (bus_addr == bse_pkg::ADDR_STATUS) begin
                next_rdata = status_byte;
            end else if (bus_in_io) begin
                next_rdata = io_regs[bus_io_idx];
            end else if (bus_in_mem) begin
                next_rdata = mem[bus_mem_idx];
            end
        end
    end

    // Read data stands in the cycle after the read strobe only; a read
    // shows the state from before the edge that samples the strobe
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_rdata <= bse_pkg::READ_ZERO;
        end else begin
            bus_rdata <= next_rdata;
        end
    end

endmodule : bse_core

`default_nettype wire

/* hdl/bse_pkg.sv */
// Purpose: Shared constants and types for the bit and skip execution unit.
// Assumes: 8-bit data path, byte-wide register port.
// Notes:   Operation codes follow enum order; see the core for meaning.
package bse_pkg;

    // Data path width
    localparam int DATA_W = 8;
    localparam int BUS_AW = 8;

    // Register port map
    localparam logic [7:0] ADDR_WREG = 8'h00;
    localparam logic [7:0] ADDR_FLAGS = 8'h01;
    localparam logic [7:0] ADDR_STATUS = 8'h02;
    localparam logic [7:0] ADDR_IO_BASE = 8'h40;
    localparam logic [7:0] ADDR_MEM_BASE = 8'h80;

    // Flag register layout
    localparam int FLAG_Z = 0;
    localparam int FLAG_C = 1;
    localparam int FLAG_HALF = 2;
    localparam int FLAG_OVF = 3;
    localparam int FLAG_W = 4;

    // Status register layout
    localparam int STATUS_SKIP = 0;

    // Reset values
    localparam logic [7:0] WREG_RST = 8'h00;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [7:0] IO_RST = 8'h00;
    localparam logic [7:0] MEM_RST = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Arithmetic constants
    localparam logic [7:0] ONE = 8'h01;
    localparam logic [7:0] BIT0_MASK = 8'h01;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int NIB_W = 4;
    localparam int SIGN_BIT = 7;

    // Operation codes; any code not listed acts as a plain slot
    typedef enum logic [3:0] {
        OP_NONE,
        OP_BIT_CLEAR_IO,
        OP_BIT_SET_IO,
        OP_BIT_CLEAR_MEM,
        OP_BIT_SET_MEM,
        OP_CMP_IMM,
        OP_CMP_MEM,
        OP_TEST_LOW_IO,
        OP_TEST_HIGH_IO,
        OP_TEST_LOW_MEM,
        OP_TEST_HIGH_MEM,
        OP_INC_WREG,
        OP_DEC_WREG,
        OP_INC_MEM,
        OP_DEC_MEM,
        OP_OTHER
    } bse_op_t;

endpackage : bse_pkg

/* tb/bse_core_properties.sv */
// Purpose: Concurrent properties of the bit and skip execution unit.
// Assumes: Sees only bse_core ports; one clock, sync reset.
// Notes:   Bound into bse_core below.
`timescale 1ns/1ps
`default_nettype none
module bse_core_properties #(
    parameter int IO_DEPTH = 16,
    parameter int MEM_DEPTH = 64
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_valid,
    input wire bse_pkg::bse_op_t instr_op,
    input wire logic [7:0] instr_addr,
    input wire logic [2:0] instr_bit,
    input wire logic [7:0] instr_imm,
    input wire logic [7:0] bus_addr,
    input wire logic [7:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [7:0] bus_rdata,
    input wire logic [7:0] working_register,
    input wire logic zero_flag,
    input wire logic carry_flag,
    input wire logic half_carry_flag,
    input wire logic overflow_flag,
    input wire logic skip_pending,
    input wire logic instr_discarded
);
    // An issue that executes rather than filling a skipped slot
    logic run;
    assign run = instr_valid && !skip_pending;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    inc_wrap_skip_a: assert property (
        run && instr_op == bse_pkg::OP_INC_WREG && working_register == 8'hff
        |=> skip_pending && zero_flag && carry_flag && working_register == 0)
        else $error("increment to zero did not skip");
    dec_zero_skip_a: assert property (
        run && instr_op == bse_pkg::OP_DEC_WREG && working_register == 8'h01
        |=> skip_pending && zero_flag && !carry_flag)
        else $error("decrement to zero did not skip");
    dec_borrow_a: assert property (
        run && instr_op == bse_pkg::OP_DEC_WREG && working_register == 8'h00
        |=> carry_flag && half_carry_flag && working_register == 8'hff)
        else $error("decrement borrow wrong");
    cmp_equal_a: assert property (
        run && !bus_wr && instr_op == bse_pkg::OP_CMP_IMM
        && instr_imm == working_register |=> skip_pending && zero_flag
        && !carry_flag && !overflow_flag && $stable(working_register))
        else $error("equal compare wrong");
    cmp_unequal_a: assert property (
        run && instr_op == bse_pkg::OP_CMP_IMM && instr_imm != working_register
        |=> !skip_pending && !zero_flag)
        else $error("unequal compare skipped");
    discard_slot_a: assert property (
        instr_valid && skip_pending && !bus_wr |=> !skip_pending
        && instr_discarded && $stable(working_register) && $stable(zero_flag))
        else $error("skipped slot not discarded");
    pulse_cause_a: assert property (
        instr_discarded |-> $past(instr_valid) && $past(skip_pending))
        else $error("discard pulse without cause");
    bit_keep_flags_a: assert property (
        run && !bus_wr && instr_op inside {
        [bse_pkg::OP_BIT_CLEAR_IO:bse_pkg::OP_BIT_SET_MEM],
        [bse_pkg::OP_TEST_LOW_IO:bse_pkg::OP_TEST_HIGH_MEM]}
        |=> $stable(zero_flag) && $stable(carry_flag)
        && $stable(half_carry_flag) && $stable(overflow_flag))
        else $error("bit operation changed flags");

    // Main scenarios reached
    cover property (run && instr_op == bse_pkg::OP_INC_MEM ##1 skip_pending);
    cover property (run && instr_op == bse_pkg::OP_CMP_MEM ##1 skip_pending);
    cover property (instr_discarded);
endmodule : bse_core_properties

bind bse_core bse_core_properties #(.IO_DEPTH(IO_DEPTH),
    .MEM_DEPTH(MEM_DEPTH)) u_bse_core_properties (.sys_clk(sys_clk),
    .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
    .instr_addr(instr_addr), .instr_bit(instr_bit), .instr_imm(instr_imm),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .working_register(working_register), .zero_flag(zero_flag),
    .carry_flag(carry_flag), .half_carry_flag(half_carry_flag),
    .overflow_flag(overflow_flag), .skip_pending(skip_pending),
    .instr_discarded(instr_discarded));
`default_nettype wire

/* tb/tb_bse_core.sv */
// Purpose: Random self-checking bench for the bit and skip unit.
// Assumes: Integer model mirrors every issued op and port write.
// Notes:   Port traffic and ops use separate cycles.
`timescale 1ns/1ps
`default_nettype none
module tb_bse_core;
    logic sys_clk, rst, instr_valid, bus_wr, bus_rd, on;
    logic z_q, c_q, hc_q, ovf_q, skip_q, disc_q;
    logic [2:0] instr_bit;
    logic [7:0] instr_addr, instr_imm, bus_addr, bus_wdata, bus_rdata, wreg_q;
    bse_pkg::bse_op_t instr_op, op;
    int n_fail, n_checks, wreg, flg, skip, disc, a, b, imm, k;
    int io [16];
    int mem [64];

    bse_core #(.IO_DEPTH(16), .MEM_DEPTH(64)) u_bse_core (
        .sys_clk(sys_clk), .rst(rst), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_addr(instr_addr), .instr_bit(instr_bit),
        .instr_imm(instr_imm), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
        .working_register(wreg_q), .zero_flag(z_q), .carry_flag(c_q),
        .half_carry_flag(hc_q), .overflow_flag(ovf_q),
        .skip_pending(skip_q), .instr_discarded(disc_q));

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    task chk(input string nm, input logic [7:0] seen, input logic [7:0] e);
        n_checks++;
        if (seen !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, seen);
        end
    endtask : chk

    task summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : summarize

    // Operand values biased toward wrap and sign boundaries
    function automatic logic [7:0] pick();
        logic [7:0] t [5] = '{8'h00, 8'h01, 8'h7f, 8'h80, 8'hff};
        int j = $urandom % 6;
        return (j == 5) ? 8'($urandom) : t[j];
    endfunction : pick

    // Model of one issued operation
    task step();
        int m, i, x, y, r, ar;
        m = a & 63;
        i = a & 15;
        x = wreg;
        y = 1;
        ar = 0;
        disc = skip;
        if (skip != 0) begin
            skip = 0;
            return;
        end
        case (op)
            bse_pkg::OP_BIT_CLEAR_IO: io[i] &= ~(1 << b);
            bse_pkg::OP_BIT_SET_IO: io[i] |= 1 << b;
            bse_pkg::OP_BIT_CLEAR_MEM: mem[m] &= ~(1 << b);
            bse_pkg::OP_BIT_SET_MEM: mem[m] |= 1 << b;
            bse_pkg::OP_TEST_LOW_IO: skip = io[i][b] == 0;
            bse_pkg::OP_TEST_HIGH_IO: skip = io[i][b];
            bse_pkg::OP_TEST_LOW_MEM: skip = mem[m][b] == 0;
            bse_pkg::OP_TEST_HIGH_MEM: skip = mem[m][b];
            bse_pkg::OP_CMP_IMM: begin
                y = imm;
                ar = 1;
            end
            bse_pkg::OP_CMP_MEM: begin
                y = mem[m];
                ar = 1;
            end
            bse_pkg::OP_INC_WREG: ar = 2;
            bse_pkg::OP_DEC_WREG: ar = 1;
            bse_pkg::OP_INC_MEM: begin
                x = mem[m];
                ar = 2;
            end
            bse_pkg::OP_DEC_MEM: begin
                x = mem[m];
                ar = 1;
            end
            default: skip = 0;
        endcase
        // Flags as a subtraction or as an increment
        if (ar == 1) begin
            r = (x - y) & 255;
            flg = int'(x < y) << 1 | int'((x & 15) < (y & 15)) << 2
                | int'(((x ^ y) & (x ^ r) & 128) != 0) << 3;
        end else if (ar == 2) begin
            r = (x + 1) & 255;
            flg = int'(x == 255) << 1 | int'((x & 15) == 15) << 2
                | int'(x == 127) << 3;
        end
        if (ar != 0) begin
            flg |= int'(r == 0);
            skip = r == 0;
        end
        if (op inside {bse_pkg::OP_INC_WREG, bse_pkg::OP_DEC_WREG}) wreg = r;
        if (op inside {bse_pkg::OP_INC_MEM, bse_pkg::OP_DEC_MEM}) mem[m] = r;
    endtask : step

    // One port write, then an idle cycle
    task wr(input logic [7:0] ad, input logic [7:0] d);
        bus_addr <= ad;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        if (ad == 8'h00) wreg = d;
        else if (ad == 8'h01) flg = d & 15;
        else if (ad >= 8'h40 && ad < 8'h50) io[ad & 15] = d;
        else if (ad >= 8'h80 && ad < 8'hc0) mem[ad & 63] = d;
        @(posedge sys_clk);
    endtask : wr

    // One port read, data checked in the following cycle
    task rd(input logic [7:0] ad, input int e);
        bus_addr <= ad;
        bus_rd <= 1'b1;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        @(negedge sys_clk);
        chk("bus_rdata", bus_rdata, 8'(e));
        @(posedge sys_clk);
    endtask : rd

    // Compare outputs with the model every cycle
    always @(negedge sys_clk) begin
        if (on) begin
            chk("wreg", wreg_q, 8'(wreg));
            chk("flags", {4'h0, ovf_q, hc_q, c_q, z_q}, 8'(flg));
            chk("skip", {7'h0, skip_q}, 8'(skip));
            chk("discard", {7'h0, disc_q}, 8'(disc));
            disc = 0;
        end
    end

    // Cut a hang short well beyond the expected run
    initial begin
        #400000;
        n_fail++;
        summarize();
    end

    initial begin
        void'($urandom(32'h42cb));
        {rst, on, instr_valid, bus_wr, bus_rd} = 5'b10000;
        instr_op = bse_pkg::OP_NONE;
        {instr_addr, instr_bit, instr_imm, bus_addr, bus_wdata} = '0;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        on = 1'b1;
        repeat (40) begin
            for (k = 0; k < 4; k++) begin
                wr(8'h40 + 8'(k), 8'($urandom));
                wr(8'h80 + 8'(k), pick());
            end
            wr(8'h00, pick());
            wr(8'h01, 8'($urandom));
            wr(8'h02, 8'hff);
            wr(8'h20, 8'hff);
            // Back to back random ops on wrapped addresses
            repeat (8) begin
                op = bse_pkg::bse_op_t'($urandom % 16);
                a = $urandom & 8'hc3;
                b = $urandom % 8;
                imm = ($urandom % 2) ? wreg : pick();
                instr_valid <= 1'b1;
                instr_op <= op;
                instr_addr <= 8'(a);
                instr_bit <= 3'(b);
                instr_imm <= 8'(imm);
                @(posedge sys_clk);
                step();
            end
            instr_valid <= 1'b0;
            @(posedge sys_clk);
            for (k = 0; k < 4; k++) begin
                rd(8'h40 + 8'(k), io[k]);
                rd(8'h80 + 8'(k), mem[k]);
            end
            rd(8'h02, skip);
            rd(8'h20, 0);
        end
        summarize();
    end
endmodule : tb_bse_core
`default_nettype wire
